/* dv/cccr_host_model.sv */
// host side model issuing byte commands to the channel config block
// assumes the block samples strobes on rising mclk; drives on falling edge
`timescale 1ns/1ps

module cccr_host_model (
    input  wire logic       mclk,
    output logic            cmdValid,
    output logic [7:0]      cmdByte,
    output logic            dataValid,
    output logic [7:0]      dataByte,
    output logic            readReq,
    input  wire logic [7:0] readByte,
    input  wire logic       readValid
);
    // ==========================================================
    // idle levels
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        dataValid = 1'b0;
        dataByte = 8'h00;
        readReq = 1'b0;
    end

    // ==========================================================
    // one command or data byte, one cycle strobe
    task automatic put(input logic isCmd, input logic [7:0] b);
        @(negedge mclk);
        if (isCmd) begin
            cmdValid = 1'b1;
            cmdByte = b;
        end else begin
            dataValid = 1'b1;
            dataByte = b;
        end
        @(negedge mclk);
        cmdValid = 1'b0;
        dataValid = 1'b0;
        cmdByte = ~cmdByte;
        dataByte = ~dataByte;
    endtask

    // ==========================================================
    // one read byte, answer one cycle after the request
    task automatic get(output logic [7:0] b);
        int n = 0;
        @(negedge mclk);
        readReq = 1'b1;
        @(negedge mclk);
        readReq = 1'b0;
        while (readValid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        b = (readValid === 1'b1) ? readByte : 8'bx;
    endtask

    // ==========================================================
    // whole register transfers, byte1 first
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
        put(1'b1, c);
        if (n == 2) put(1'b0, d[15:8]);
        put(1'b0, d[7:0]);
    endtask

    task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d);
        logic [7:0] b;
        put(1'b1, c);
        d = 16'h0000;
        repeat (n) begin
            get(b);
            d = {d[7:0], b};
        end
    endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the channel configuration register group
// assumes cccr_pkg compiled first and the host model drives the command port
`timescale 1ns/1ps

module tb_top;
    localparam logic [7:0] REV = 8'h5a; // arbitrary value
    logic mclk, reset, cmdValid, dataValid, readReq, readValid, lineIntEvent;
    logic [7:0] cmdByte, dataByte, readByte, lineBits;
    logic [3:0] chanEnable, codingLinear, muLaw, txPathEnable, rxPathEnable, bStageEnable, highpassEnable;
    logic [3:0] rxLossInsert, txIntArm, interfaceLoopback, fullDigitalLoopback, testToneEnable;
    logic [23:0] programSelect;
    logic [95:0] txGain, rxGain;
    logic [15:0] rdv;
    logic [7:0] b;
    int failCount = 0;
    int compares = 0;
    int cycles = 0;

    // ==========================================================
    // clock, parts
    always #50 mclk = ~mclk;

    cccr_host_model host (.mclk(mclk), .cmdValid(cmdValid), .cmdByte(cmdByte), .dataValid(dataValid),
        .dataByte(dataByte), .readReq(readReq), .readByte(readByte), .readValid(readValid));

    cccr_channel_config #(.REVISION_CODE(REV)) dut (.mclk(mclk), .reset(reset), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .dataValid(dataValid), .dataByte(dataByte), .readReq(readReq),
        .readByte(readByte), .readValid(readValid), .chanEnable(chanEnable), .lineBits(lineBits),
        .lineIntEvent(lineIntEvent), .codingLinear(codingLinear), .muLaw(muLaw),
        .programSelect(programSelect), .txPathEnable(txPathEnable), .rxPathEnable(rxPathEnable),
        .bStageEnable(bStageEnable), .highpassEnable(highpassEnable), .rxLossInsert(rxLossInsert),
        .txIntArm(txIntArm), .interfaceLoopback(interfaceLoopback),
        .fullDigitalLoopback(fullDigitalLoopback), .testToneEnable(testToneEnable),
        .txGain(txGain), .rxGain(rxGain));

    // ==========================================================
    // helpers
    function automatic logic [95:0] g4(input logic [15:0] c, input logic one);
        logic signed [23:0] x;
        logic signed [23:0] t;
        x = 24'sh010000;
        for (int i = 3; i >= 0; i--) begin
            t = x >>> c[i*4+:3];
            t = c[i*4+3] ? -t : t;
            x = (i == 0) ? t : 24'sh010000 + t;
        end
        x = one ? x + 24'sh010000 : x;
        return {4{x}};
    endfunction

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic closeOut;
        if (failCount == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask

    // ==========================================================
    // scenarios
    task automatic tReset;
        chk({codingLinear, muLaw, programSelect}, 32'h0);
        chk({txPathEnable, rxPathEnable, bStageEnable, highpassEnable}, 16'hffff);
        chk({rxLossInsert, txIntArm, interfaceLoopback, fullDigitalLoopback, testToneEnable}, 20'h0);
        chk(txGain, g4(16'ha9f0, 1'b1));
        chk(rxGain, g4(16'h23a1, 1'b0));
        host.rd(8'h61, 1, rdv);
        chk(rdv, 16'h0000);
        host.rd(8'h6d, 1, rdv);
        chk(rdv, 16'h00ff);
        host.rd(8'h71, 1, rdv);
        chk(rdv, 16'h0000);
        host.rd(8'h81, 2, rdv);
        chk(rdv, 16'ha9f0);
        host.rd(8'h83, 2, rdv);
        chk(rdv, 16'h23a1);
        host.rd(8'h73, 1, rdv);
        chk(rdv, {8'h00, REV});
    endtask

    task automatic tOpFunc;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            host.wr(8'h60, {8'h00, b}, 1);
            settle;
            chk({codingLinear, muLaw, programSelect}, {{4{b[7]}}, {4{b[6]}}, {4{b[5:0]}}});
            host.rd(8'h61, 1, rdv);
            chk(rdv, {8'h00, b});
        end
        host.wr(8'h60, 16'h0000, 1);
        host.wr(8'h82, 16'h9111, 2);
        host.wr(8'h80, 16'h0000, 2);
        settle;
        chk({txGain, rxGain}, {g4(16'ha9f0, 1'b1), g4(16'h23a1, 1'b0)});
        host.rd(8'h83, 2, rdv);
        chk(rdv, 16'h9111);
        host.wr(8'h60, 16'h0030, 1);
        settle;
        chk({txGain, rxGain}, {g4(16'h0000, 1'b1), g4(16'h9111, 1'b0)});
        host.wr(8'h60, 16'h0000, 1);
        settle;
        chk({txGain, rxGain}, {g4(16'ha9f0, 1'b1), g4(16'h23a1, 1'b0)});
    endtask

    task automatic tOpCond;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            host.wr(8'h70, {8'h00, b}, 1);
            settle;
            chk({txPathEnable, rxPathEnable, bStageEnable, highpassEnable},
                {{4{~b[7]}}, {4{~b[6]}}, {4{~b[6]}}, {4{~b[5]}}});
            chk({rxLossInsert, txIntArm, interfaceLoopback, fullDigitalLoopback, testToneEnable},
                {{4{b[4]}}, {4{b[3]}}, {4{b[2]}}, {4{b[1]}}, {4{b[0]}}});
            host.rd(8'h71, 1, rdv);
            chk(rdv, {8'h00, b});
        end
    endtask

    task automatic tEnable;
        chanEnable = 4'b0100;
        host.wr(8'h70, 16'h0011, 1);
        settle;
        chk({rxLossInsert, testToneEnable}, 8'h44);
        host.rd(8'h71, 1, rdv);
        chk(rdv, 16'h0011);
        chanEnable = 4'b0000;
        host.wr(8'h70, 16'h00ff, 1);
        settle;
        chk({rxLossInsert, testToneEnable}, 8'h44);
        host.rd(8'h71, 1, rdv);
        chk(rdv, 16'h0000);
        host.wr(8'h6c, 16'h00a5, 1);
        host.rd(8'h6d, 1, rdv);
        chk(rdv, 16'h00a5);
        host.rd(8'h73, 1, rdv);
        chk(rdv, {8'h00, REV});
        chanEnable = 4'hf;
        host.wr(8'h6c, 16'h00ff, 1);
    endtask

    task automatic lineStep(input logic [7:0] v, input logic e);
        lineBits = v;
        @(negedge mclk);
        chk(lineIntEvent, e);
        @(negedge mclk);
        chk(lineIntEvent, 1'b0);
    endtask

    task automatic tLine;
        @(negedge mclk);
        lineStep(8'h03, 1'b0);
        host.wr(8'h6c, 16'h00fe, 1);
        settle;
        lineStep(8'h01, 1'b0);
        lineStep(8'h00, 1'b1);
        lineStep(8'h80, 1'b0);
    endtask

    task automatic tLone;
        host.put(1'b1, 8'h80);
        host.put(1'b0, 8'h12);
        host.rd(8'h81, 2, rdv);
        chk(rdv, 16'h0000);
    endtask

    // ==========================================================
    // sequence and hang guard
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        chanEnable = 4'hf;
        lineBits = 8'h00;
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        tReset;
        tOpFunc;
        tOpCond;
        tEnable;
        tLine;
        tLone;
        closeOut;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            closeOut;
        end
    end
endmodule

/* verilog/cccr_channel_config.sv */
// per-channel configuration registers reached by host byte commands
// assumes command, data and read strobes and line bits come from mclk logic
// Overview of operation
// R1 - 60/61 write/read operating function byte
// R2 - bit7 linear coding, bit6 mu-law law
// R3 - select bits pick default or programmed coefficients
// R4 - default gains fixed, separate from programmed
// R5 - 6C/6D mask byte, resets to ff
// R6 - masked line change never raises interrupt
// R7 - mask and revision ignore channel enables
// R8 - 70/71 operating conditions byte, reset zero
// R9 - transmit cutoff bit disconnects transmit path
// R10 - receive cutoff bit cuts receive path
// R11 - receive cutoff also disables b stage
// R12 - highpass active unless bypass bit set
// R13 - receive loss bit inserts 6 dB
// R14 - arm bit arms transmit interrupt
// R15 - interface loopback bit enables slot loopback
// R16 - full digital loopback bit enables it
// R17 - tone bit injects 1 kHz receive tone
// R18 - 73 reads fixed 8-bit revision code
// R19 - sign field 0 is plus, 1 minus
// R20 - 80/81 transmit gain, byte1 then byte2
// R21 - transmit gain is one plus nested product
// R22 - 82/83 receive gain, nibble sign shift
// R23 - receive gain nested product, reset 23a1
// R24 - per-channel commands need channel enable set
// R25 - reads return stored value, no side effect
`timescale 1ns/1ps

module cccr_channel_config #(
    parameter logic [7:0] REVISION_CODE = 8'h01  // arbitrary value
) (
    input  wire logic                                       mclk,
    input  wire logic                                       reset,
    input  wire logic                                       cmdValid,
    input  wire logic [7:0]                                 cmdByte,
    input  wire logic                                       dataValid,
    input  wire logic [7:0]                                 dataByte,
    input  wire logic                                       readReq,
    output logic [7:0]                                      readByte,
    output logic                                            readValid,
    input  wire logic [cccr_pkg::NCH-1:0]                   chanEnable,
    input  wire logic [7:0]                                 lineBits,
    output logic                                            lineIntEvent,
    output logic [cccr_pkg::NCH-1:0]                        codingLinear,
    output logic [cccr_pkg::NCH-1:0]                        muLaw,
    output logic [cccr_pkg::NCH*6-1:0]                      programSelect,
    output logic [cccr_pkg::NCH-1:0]                        txPathEnable,
    output logic [cccr_pkg::NCH-1:0]                        rxPathEnable,
    output logic [cccr_pkg::NCH-1:0]                        bStageEnable,
    output logic [cccr_pkg::NCH-1:0]                        highpassEnable,
    output logic [cccr_pkg::NCH-1:0]                        rxLossInsert,
    output logic [cccr_pkg::NCH-1:0]                        txIntArm,
    output logic [cccr_pkg::NCH-1:0]                        interfaceLoopback,
    output logic [cccr_pkg::NCH-1:0]                        fullDigitalLoopback,
    output logic [cccr_pkg::NCH-1:0]                        testToneEnable,
    output logic [cccr_pkg::NCH*cccr_pkg::GAIN_W-1:0]       txGain,
    output logic [cccr_pkg::NCH*cccr_pkg::GAIN_W-1:0]       rxGain
);

    // ==========================================================
    // helper functions
    function automatic logic isTwoByte(input logic [7:0] c);
        return (c == cccr_pkg::CMD_TXGAIN_WR) || (c == cccr_pkg::CMD_RXGAIN_WR) ||
               (c == cccr_pkg::CMD_TXGAIN_RD) || (c == cccr_pkg::CMD_RXGAIN_RD);
    endfunction

    // one signed shift stage of a coefficient
    function automatic logic signed [cccr_pkg::GAIN_W-1:0] gainStage(
        input logic [3:0]                            nib,
        input logic signed [cccr_pkg::GAIN_W-1:0]   x
    );
        logic signed [cccr_pkg::GAIN_W-1:0] v;
        v = x >>> nib[2:0];
        return nib[3] ? -v : v;  // see R19
    endfunction

    // nested gain product in q8.16
    function automatic logic signed [cccr_pkg::GAIN_W-1:0] gainValue(
        input logic [15:0] c,
        input logic        addOne
    );
        logic signed [cccr_pkg::GAIN_W-1:0] t;
        t = cccr_pkg::GAIN_ONE + gainStage(c[15:12], cccr_pkg::GAIN_ONE);  // see R22
        t = cccr_pkg::GAIN_ONE + gainStage(c[11:8], t);
        t = cccr_pkg::GAIN_ONE + gainStage(c[7:4], t);
        t = gainStage(c[3:0], t);
        return addOne ? cccr_pkg::GAIN_ONE + t : t;  // see R21 see R23
    endfunction

    // lowest enabled channel index, for reads
    function automatic logic [1:0] lowestChan(input logic [cccr_pkg::NCH-1:0] en);
        logic [1:0] idx;
        idx = 2'd0;
        for (int i = cccr_pkg::NCH - 1; i >= 0; i--) begin
            if (en[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // ==========================================================
    // state
    cccr_pkg::cccr_regs_t q;
    cccr_pkg::cccr_regs_t n;

    logic       wrCommit;
    logic [1:0] rdChan;
    logic       anyEn;
    logic [7:0] lineChange;

    assign wrCommit   = (q.st == cccr_pkg::ST_WR) && dataValid && !cmdValid &&
                        (!isTwoByte(q.cmd) || q.firstDone);
    assign rdChan     = lowestChan(chanEnable);
    assign anyEn      = |chanEnable;
    assign lineChange = lineBits ^ q.lineSeen;

    // ==========================================================
    // next state
    always_comb begin
        n         = q;
        n.rdValid = 1'b0;
        n.lineSeen = lineBits;
        n.lineEvt = |(lineChange & ~q.mask);  // see R6 see R7

        if (cmdValid) begin
            n.cmd       = cmdByte;
            n.firstDone = 1'b0;
            n.target    = chanEnable;  // see R24
            n.rdLeft    = isTwoByte(cmdByte) ? 2'd2 : 2'd1;
            n.st        = cccr_pkg::ST_RD;
            unique case (cmdByte)
                cccr_pkg::CMD_OPFUNC_WR, cccr_pkg::CMD_MASK_WR, cccr_pkg::CMD_OPCOND_WR,
                cccr_pkg::CMD_TXGAIN_WR, cccr_pkg::CMD_RXGAIN_WR: begin
                    n.st = cccr_pkg::ST_WR;
                end
                cccr_pkg::CMD_OPFUNC_RD: begin
                    n.rdShift = {anyEn ? q.opFunc[rdChan] : 8'h00, 8'h00};  // see R1 see R25
                end
                cccr_pkg::CMD_MASK_RD: begin
                    n.rdShift = {q.mask, 8'h00};  // see R5 see R7
                end
                cccr_pkg::CMD_OPCOND_RD: begin
                    n.rdShift = {anyEn ? q.opCond[rdChan] : 8'h00, 8'h00};  // see R8
                end
                cccr_pkg::CMD_REV_RD: begin
                    n.rdShift = {REVISION_CODE, 8'h00};  // see R18
                end
                cccr_pkg::CMD_TXGAIN_RD: begin
                    n.rdShift = anyEn ? q.txCoef[rdChan] : 16'h0000;  // see R20
                end
                cccr_pkg::CMD_RXGAIN_RD: begin
                    n.rdShift = anyEn ? q.rxCoef[rdChan] : 16'h0000;  // see R22
                end
                default: begin
                    n.st = cccr_pkg::ST_IDLE;
                end
            endcase
        end else begin
            unique case (q.st)
                cccr_pkg::ST_IDLE: begin
                end
                cccr_pkg::ST_WR: begin
                    if (dataValid && !wrCommit) begin
                        n.hold      = dataByte;
                        n.firstDone = 1'b1;
                    end
                    if (wrCommit) begin
                        n.st = cccr_pkg::ST_IDLE;
                        if (q.cmd == cccr_pkg::CMD_MASK_WR) begin
                            n.mask = dataByte;  // see R5 see R7
                        end
                        for (int c = 0; c < cccr_pkg::NCH; c++) begin
                            if (q.target[c]) begin  // see R24
                                if (q.cmd == cccr_pkg::CMD_OPFUNC_WR) begin
                                    n.opFunc[c] = dataByte;  // see R1
                                end
                                if (q.cmd == cccr_pkg::CMD_OPCOND_WR) begin
                                    n.opCond[c] = dataByte;  // see R8
                                end
                                if (q.cmd == cccr_pkg::CMD_TXGAIN_WR) begin
                                    n.txCoef[c] = {q.hold, dataByte};  // see R20
                                end
                                if (q.cmd == cccr_pkg::CMD_RXGAIN_WR) begin
                                    n.rxCoef[c] = {q.hold, dataByte};  // see R22
                                end
                            end
                        end
                    end
                end
                cccr_pkg::ST_RD: begin
                    if (readReq && q.rdLeft != 2'd0) begin
                        n.rdByte  = q.rdShift[15:8];  // see R25
                        n.rdShift = {q.rdShift[7:0], 8'h00};
                        n.rdValid = 1'b1;
                        n.rdLeft  = q.rdLeft - 2'd1;
                        if (q.rdLeft == 2'd1) begin
                            n.st = cccr_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end

        // gains from fixed defaults or programmed store
        for (int c = 0; c < cccr_pkg::NCH; c++) begin
            n.txGain[c] = gainValue(n.opFunc[c][cccr_pkg::OF_SEL_TX] ? n.txCoef[c]
                                                                    : cccr_pkg::TXGAIN_RST, 1'b1);  // see R3 see R4
            n.rxGain[c] = gainValue(n.opFunc[c][cccr_pkg::OF_SEL_RX] ? n.rxCoef[c]
                                                                    : cccr_pkg::RXGAIN_RST, 1'b0);  // see R3 see R4
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q           <= '0;
            q.st        <= cccr_pkg::ST_IDLE;
            q.mask      <= cccr_pkg::MASK_RST;  // see R5
            q.opFunc    <= {cccr_pkg::NCH{cccr_pkg::OPFUNC_RST}};
            q.opCond    <= {cccr_pkg::NCH{cccr_pkg::OPCOND_RST}};
            q.txCoef    <= {cccr_pkg::NCH{cccr_pkg::TXGAIN_RST}};
            q.rxCoef    <= {cccr_pkg::NCH{cccr_pkg::RXGAIN_RST}};  // see R23
            q.txGain    <= {cccr_pkg::NCH{cccr_pkg::TXGAIN_VAL_RST}};  // see R21
            q.rxGain    <= {cccr_pkg::NCH{cccr_pkg::RXGAIN_VAL_RST}};  // see R23
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign readByte     = q.rdByte;
    assign readValid    = q.rdValid;
    assign lineIntEvent = q.lineEvt;

    for (genvar c = 0; c < cccr_pkg::NCH; c++) begin : g_ch
        assign codingLinear[c]        = q.opFunc[c][cccr_pkg::OF_LINEAR];  // see R2
        assign muLaw[c]               = q.opFunc[c][cccr_pkg::OF_MULAW];   // see R2
        assign programSelect[c*6 +: 6] = q.opFunc[c][cccr_pkg::OF_SEL_LO +: 6];  // see R3
        assign txPathEnable[c]        = !q.opCond[c][cccr_pkg::OC_TXCUT];  // see R9
        assign rxPathEnable[c]        = !q.opCond[c][cccr_pkg::OC_RXCUT];  // see R10
        assign bStageEnable[c]        = !q.opCond[c][cccr_pkg::OC_RXCUT];  // see R11
        assign highpassEnable[c]      = !q.opCond[c][cccr_pkg::OC_HPBYP];  // see R12
        assign rxLossInsert[c]        = q.opCond[c][cccr_pkg::OC_RXLOSS];  // see R13
        assign txIntArm[c]            = q.opCond[c][cccr_pkg::OC_TXARM];   // see R14
        assign interfaceLoopback[c]   = q.opCond[c][cccr_pkg::OC_IFLOOP];  // see R15
        assign fullDigitalLoopback[c] = q.opCond[c][cccr_pkg::OC_FDLOOP];  // see R16
        assign testToneEnable[c]      = q.opCond[c][cccr_pkg::OC_TONE];    // see R17
        assign txGain[c*cccr_pkg::GAIN_W +: cccr_pkg::GAIN_W] = q.txGain[c];
        assign rxGain[c*cccr_pkg::GAIN_W +: cccr_pkg::GAIN_W] = q.rxGain[c];
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_masked_silent: assert property (lineIntEvent |-> $past(|(lineChange & ~q.mask)))  // see R6
        else $error("line event without unmasked change");
    a_unmasked_fires: assert property (|(lineChange & ~q.mask) |=> lineIntEvent)  // see R6
        else $error("unmasked line change lost");
    a_mask_ungated: assert property (  // see R7
        wrCommit && q.cmd == cccr_pkg::CMD_MASK_WR |=> q.mask == $past(dataByte))
        else $error("mask write not applied");
    a_chan_gated: assert property (  // see R24
        wrCommit && !q.target[0] |=> $stable(q.opFunc[0]) && $stable(q.opCond[0])
        && $stable(q.txCoef[0]) && $stable(q.rxCoef[0]))
        else $error("disabled channel changed");
    a_rxcut_bstage: assert property (  // see R11
        wrCommit && q.target[0] && q.cmd == cccr_pkg::CMD_OPCOND_WR && dataByte[cccr_pkg::OC_RXCUT]
        |=> !bStageEnable[0] && !rxPathEnable[0])
        else $error("b stage still on in receive cutoff");
    a_default_kept: assert property (  // see R4
        wrCommit && q.target[0] && q.cmd == cccr_pkg::CMD_TXGAIN_WR && !q.opFunc[0][cccr_pkg::OF_SEL_TX]
        |=> $stable(q.txGain[0]))
        else $error("default gain altered by coefficient write");
    a_gain_order: assert property (  // see R22
        wrCommit && q.target[0] && q.cmd == cccr_pkg::CMD_RXGAIN_WR
        |=> q.rxCoef[0] == {$past(q.hold), $past(dataByte)})
        else $error("gain bytes stored out of order");
    a_rev_read: assert property (  // see R18
        q.st == cccr_pkg::ST_RD && q.cmd == cccr_pkg::CMD_REV_RD && q.rdLeft == 2'd1 && readReq && !cmdValid
        |=> readValid && readByte == REVISION_CODE)
        else $error("revision read wrong");
    a_read_clean: assert property (  // see R25
        cmdValid && cmdByte[0] |=> $stable(q.opFunc) && $stable(q.opCond)
        && $stable(q.mask) && $stable(q.txCoef))
        else $error("read changed state");

    c_two_byte_wr: cover property (wrCommit && q.cmd == cccr_pkg::CMD_TXGAIN_WR);
    c_two_byte_rd: cover property (readValid ##[1:4] readValid);
    c_line_event: cover property (lineIntEvent);
    c_cutoff: cover property (!bStageEnable[0]);

endmodule

/* verilog/cccr_pkg.sv */
// package for the codec channel configuration register group
// assumes one 10 MHz clock domain and byte-wide command decoding upstream
package cccr_pkg;

    // ==========================================================
    // channel count and gain number format
    localparam int NCH       = 4;
    localparam int GAIN_W    = 24;
    localparam logic signed [GAIN_W-1:0] GAIN_ONE = 24'sh010000;

    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_OPFUNC_WR = 8'h60;
    localparam logic [7:0] CMD_OPFUNC_RD = 8'h61;
    localparam logic [7:0] CMD_MASK_WR   = 8'h6c;
    localparam logic [7:0] CMD_MASK_RD   = 8'h6d;
    localparam logic [7:0] CMD_OPCOND_WR = 8'h70;
    localparam logic [7:0] CMD_OPCOND_RD = 8'h71;
    localparam logic [7:0] CMD_REV_RD    = 8'h73;
    localparam logic [7:0] CMD_TXGAIN_WR = 8'h80;
    localparam logic [7:0] CMD_TXGAIN_RD = 8'h81;
    localparam logic [7:0] CMD_RXGAIN_WR = 8'h82;
    localparam logic [7:0] CMD_RXGAIN_RD = 8'h83;

    // ==========================================================
    // reset values, also the fixed default gain coefficients
    localparam logic [7:0]  OPFUNC_RST = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'hff;
    localparam logic [7:0]  OPCOND_RST = 8'h00;
    localparam logic [15:0] TXGAIN_RST = 16'ha9f0;
    localparam logic [15:0] RXGAIN_RST = 16'h23a1;
    // evaluated gains of the default coefficients, q8.16
    localparam logic [GAIN_W-1:0] TXGAIN_VAL_RST = 24'h01fec0;
    localparam logic [GAIN_W-1:0] RXGAIN_VAL_RST = 24'h005b00;

    // ==========================================================
    // operating function fields
    localparam int OF_LINEAR = 7;
    localparam int OF_MULAW  = 6;
    localparam int OF_SEL_RX = 5;
    localparam int OF_SEL_TX = 4;
    localparam int OF_SEL_LO = 0;

    // ==========================================================
    // operating condition fields
    localparam int OC_TXCUT  = 7;
    localparam int OC_RXCUT  = 6;
    localparam int OC_HPBYP  = 5;
    localparam int OC_RXLOSS = 4;
    localparam int OC_TXARM  = 3;
    localparam int OC_IFLOOP = 2;
    localparam int OC_FDLOOP = 1;
    localparam int OC_TONE   = 0;

    // ==========================================================
    // command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR   = 3'b010,
        ST_RD   = 3'b100
    } cccr_state_t;

    typedef struct packed {
        cccr_state_t                    st;
        logic [7:0]                     cmd;
        logic [7:0]                     hold;
        logic                           firstDone;
        logic [NCH-1:0]                 target;
        logic [15:0]                    rdShift;
        logic [1:0]                     rdLeft;
        logic [7:0]                     rdByte;
        logic                           rdValid;
        logic [NCH-1:0][7:0]            opFunc;
        logic [NCH-1:0][7:0]            opCond;
        logic [NCH-1:0][15:0]           txCoef;
        logic [NCH-1:0][15:0]           rxCoef;
        logic [7:0]                     mask;
        logic [7:0]                     lineSeen;
        logic                           lineEvt;
        logic [NCH-1:0][GAIN_W-1:0]     txGain;
        logic [NCH-1:0][GAIN_W-1:0]     rxGain;
    } cccr_regs_t;

endpackage
